// file: verilog/dpc_pkg.sv
// constants, types and register map of the dram mode-exit controller
package dpc_pkg;
  // clock and interval figures, times in ns
  localparam int CLK_NS        = 50;
  localparam int CKMPX_NS      = 200;
  localparam int XMPLH_NS      = 100;
  localparam int XMP_NS        = 1000;
  localparam int XMP_DLL_NS    = 20000;
  localparam int MRD_PDA_NS    = 10;
  // least times, rounded up to whole cycles
  localparam int CKMPX_CYC     = (CKMPX_NS + CLK_NS - 1) / CLK_NS;
  localparam int XMPLH_CYC     = (XMPLH_NS + CLK_NS - 1) / CLK_NS;
  localparam int XMP_CYC       = (XMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int XMP_DLL_CYC   = (XMP_DLL_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_PDA_CYC   = (MRD_PDA_NS + CLK_NS - 1) / CLK_NS;
  // 3.5 clocks of mrs spacing rounded up, and the data burst in clocks
  localparam int SPACE_EXTRA_CK = 4;
  localparam int BURST_CK       = 4;
  localparam int TW             = 16;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MRS    = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // control bits (write-only pulses)
  localparam int CTRL_PARK = 0;
  localparam int CTRL_EXIT = 1;
  localparam int CTRL_MRS  = 2;
  // mrs register fields
  localparam int MRS_ADDR_LSB = 0;
  localparam int MRS_ADDR_W   = 14;
  localparam int MRS_SEL_LSB  = 14;
  localparam int MRS_SKIP     = 17;
  localparam int MRS_NEED_DLL = 18;
  // config register fields
  localparam int CFG_LAT_LSB  = 0;
  localparam int CFG_LAT_W    = 6;
  localparam int CFG_WL_DONE  = 6;
  localparam int CFG_NOM_TERM = 7;
  // status bits
  localparam int ST_IDLE     = 0;
  localparam int ST_PARKED   = 1;
  localparam int ST_XMP_DONE = 2;
  localparam int ST_DLL_OK   = 3;
  localparam int ST_PDA      = 4;
  localparam int ST_VREF_SET = 5;
  localparam int ST_ERR_REF  = 6;
  localparam int ST_ERR_RES  = 7;

  // mode register numbers and bits
  localparam logic [2:0] MR_PDA      = 3'h3;
  localparam int         PDA_BIT     = 4;
  localparam logic [2:0] MR_VREF     = 3'h6;
  localparam int         VREF_EN_BIT = 7;
  localparam logic [5:0] VREF_MAX    = 6'h32;

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_PARK      = 4'h1,
    S_WAKE_CK   = 4'h2,
    S_WAKE_HOLD = 4'h3,
    S_WAKE_DES  = 4'h4,
    S_MRS_CMD   = 4'h5,
    S_MRS_GAP   = 4'h6
  } dpc_state_e;

  typedef enum logic [1:0] {
    CMD_DES = 2'h0,
    CMD_NOP = 2'h1,
    CMD_MRS = 2'h2
  } dpc_cmd_e;
endpackage

// file: verilog/dpc_tmr_if.sv
// load and count signals between the controller and a down timer
`timescale 1ns/10ps
interface dpc_tmr_if;
  import dpc_pkg::*;
  logic          load;
  logic [TW-1:0] value;
  logic [TW-1:0] count;
  logic          done;
  modport ctl (output load, output value, input count, input done);
  modport tmr (input load, input value, output count, output done);
endinterface

// file: verilog/dpc_timer.sv
// down counter that loads a cycle count and flags zero
`timescale 1ns/10ps
module dpc_timer
  import dpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dpc_tmr_if.tmr   t
);
  logic [TW-1:0] count;

  assign t.count = count;
  assign t.done  = (count == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (t.load) begin
      count <= t.value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
endmodule

// file: verilog/dpc_ctrl.sv
// apb-controlled driver for power-save exit, per-device mrs and vref
//
// Overview of operation
// - cs_n low at cke rising edge exits
// - clock restarted and stable before cke rises
// - nop during hold window, then des
// - commands wait for exit or dll interval
// - dq0 held steady over whole burst
// - write leveling before enabling per-device mode
// - only mrs issued in per-device mode; a park there is not refused, and its exit drives nop with cs_n low
// - mrs spacing latency plus 3.5 plus delay
// - exit per-device mode with dq0 low
// - termination follows odt pin in per-device mode
// - vref has no default, must be programmed
`timescale 1ns/10ps
module dpc_ctrl
  import dpc_pkg::*;
#(
  parameter int DLL_CYC = XMP_DLL_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ck_en,
  output logic             cke,
  output logic             cs_n,
  output logic      [1:0]  cmd,
  output logic      [2:0]  mr_sel,
  output logic      [13:0] mr_addr,
  output logic             dq0_out,
  output logic             dq0_oe,
  output logic             dqs_out,
  output logic             dqs_oe,
  output logic             odt
);
  dpc_tmr_if  seq_t ();
  dpc_tmr_if  dll_t ();
  dpc_timer u_seq (.pclk(pclk), .presetn(presetn), .t(seq_t.tmr));
  dpc_timer u_dll (.pclk(pclk), .presetn(presetn), .t(dll_t.tmr));

  dpc_state_e  state;
  dpc_state_e  next_state;
  logic [31:0] mrs_reg;
  logic [7:0]  cfg_reg;
  logic        parked;
  logic        xmp_done;
  logic        dll_ok;
  logic        pda_on;
  logic        gap_pda;
  logic        vref_set;
  logic        err_ref;
  logic        err_res;

  // apb decode; pready is a plain flip-flop set from the setup phase, so no wait state
  wire         acc      = psel & penable & pready;
  wire         wr       = acc & pwrite;
  wire         hit_ctrl = (paddr == REG_CTRL);
  wire         hit_mrs  = (paddr == REG_MRS);
  wire         hit_cfg  = (paddr == REG_CFG);
  wire         hit_st   = (paddr == REG_STATUS);
  wire         mapped   = hit_ctrl | hit_mrs | hit_cfg | hit_st;
  wire         go_park  = wr & hit_ctrl & pwdata[CTRL_PARK];
  wire         go_exit  = wr & hit_ctrl & pwdata[CTRL_EXIT];
  wire         go_mrs   = wr & hit_ctrl & pwdata[CTRL_MRS];
  wire         st_clr   = wr & hit_st;
  wire         is_idle  = (state == S_IDLE);

  wire [13:0]  m_addr   = mrs_reg[MRS_ADDR_LSB +: MRS_ADDR_W];
  wire [2:0]   m_sel    = mrs_reg[MRS_SEL_LSB +: 3];
  wire         m_skip   = mrs_reg[MRS_SKIP];
  wire         m_dll    = mrs_reg[MRS_NEED_DLL];
  wire [5:0]   lat      = cfg_reg[CFG_LAT_LSB +: CFG_LAT_W];
  wire         wl_done  = cfg_reg[CFG_WL_DONE];
  wire         nom_term = cfg_reg[CFG_NOM_TERM];

  // checks on a queued mrs before it leaves
  wire vref_bad = (m_sel == MR_VREF) && (m_addr[5:0] > VREF_MAX);
  wire pda_early = (m_sel == MR_PDA) && m_addr[PDA_BIT] && !wl_done;
  wire dll_early = m_dll && !dll_ok;
  wire mrs_ok   = is_idle && xmp_done && !vref_bad && !pda_early
                  && !dll_early;
  wire mrs_bad  = go_mrs && !mrs_ok;
  wire exit_bad = go_exit && (state != S_PARK);
  wire park_bad = go_park && !is_idle;
  // leaving per-device mode must always reach every device
  wire pda_exit = (m_sel == MR_PDA) && !m_addr[PDA_BIT];
  wire dq_level = m_skip && !pda_exit;

  // data burst window counted back from the end of the mrs gap
  wire [TW-1:0] gap_cnt = TW'(lat) + TW'(SPACE_EXTRA_CK)
                          + TW'(MRD_PDA_CYC);
  wire in_burst = (state == S_MRS_GAP) && gap_pda
                  && (seq_t.count > TW'(MRD_PDA_CYC))
                  && (seq_t.count <= TW'(MRD_PDA_CYC + BURST_CK));
  wire mrs_lands = (state == S_MRS_CMD) && !(pda_on && dq_level);

  wire [31:0] status = {24'h0, err_res, err_ref, vref_set, pda_on,
                        dll_ok, xmp_done, parked, is_idle};
  wire [31:0] rd_mux = hit_mrs ? mrs_reg :
                       hit_cfg ? {24'h0, cfg_reg} :
                       hit_st  ? status : 32'h0;

  // sequencer; timers loaded at the moment a stage begins
  always_comb begin
    next_state    = state;
    seq_t.load    = 1'b0;
    seq_t.value   = '0;
    dll_t.load    = 1'b0;
    dll_t.value   = '0;
    case (state)
      S_IDLE: begin
        if (go_park) begin
          next_state = S_PARK;
        end else if (go_mrs && mrs_ok) begin
          next_state = S_MRS_CMD;
        end
      end
      S_PARK: begin
        if (go_exit) begin
          next_state  = S_WAKE_CK;
          seq_t.load  = 1'b1;
          seq_t.value = TW'(CKMPX_CYC);
        end
      end
      S_WAKE_CK: begin
        if (seq_t.done) begin
          next_state  = S_WAKE_HOLD;
          seq_t.load  = 1'b1;
          seq_t.value = TW'(XMPLH_CYC);
          dll_t.load  = 1'b1;
          dll_t.value = TW'(DLL_CYC);
        end
      end
      S_WAKE_HOLD: begin
        if (seq_t.done) begin
          next_state  = S_WAKE_DES;
          seq_t.load  = 1'b1;
          seq_t.value = TW'(XMP_CYC - XMPLH_CYC);
        end
      end
      S_WAKE_DES: begin
        if (seq_t.done) begin
          next_state = S_IDLE;
        end
      end
      S_MRS_CMD: begin
        next_state  = S_MRS_GAP;
        seq_t.load  = 1'b1;
        seq_t.value = pda_on ? gap_cnt : TW'(MRD_PDA_CYC);
      end
      S_MRS_GAP: begin
        if (seq_t.done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // pin levels per state; parity pins do not exist here
  wire       n_ck_en = !(next_state == S_PARK);
  wire       n_cke   = !(next_state == S_PARK || next_state == S_WAKE_CK);
  wire       n_hold  = (next_state == S_WAKE_CK)
                       || (next_state == S_WAKE_HOLD);
  wire       n_mrs   = (next_state == S_MRS_CMD);
  wire       n_cs_n  = !(n_hold || n_mrs);
  wire [1:0] n_cmd   = n_mrs ? CMD_MRS :
                       (next_state == S_WAKE_HOLD) ? CMD_NOP : CMD_DES;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      ck_en <= 1'b1;
      cke   <= 1'b1;
      cs_n  <= 1'b1;
      cmd   <= CMD_DES;
    end else begin
      state <= next_state;
      ck_en <= n_ck_en;
      cke   <= n_cke;
      cs_n  <= n_cs_n;
      cmd   <= n_cmd;
    end
  end

  // mrs address and data pins; odt follows the burst when nom_term is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_sel  <= '0;
      mr_addr <= '0;
      dq0_out <= 1'b0;
      dq0_oe  <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe  <= 1'b0;
      odt     <= 1'b0;
    end else begin
      mr_sel  <= m_sel;
      mr_addr <= m_addr;
      dq0_out <= dq_level;
      dq0_oe  <= in_burst;
      dqs_out <= in_burst && !dqs_out;
      dqs_oe  <= in_burst;
      odt     <= in_burst && nom_term;
    end
  end

  // registers written from the bus; mrs frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrs_reg <= '0;
      cfg_reg <= '0;
    end else begin
      if (wr && hit_mrs && is_idle) begin
        mrs_reg <= pwdata;
      end
      if (wr && hit_cfg) begin
        cfg_reg <= pwdata[7:0];
      end
    end
  end

  // mode tracking; vref known only once an mr6 write lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parked   <= 1'b0;
      xmp_done <= 1'b1;
      dll_ok   <= 1'b1;
      pda_on   <= 1'b0;
      vref_set <= 1'b0;
      gap_pda  <= 1'b0;
    end else begin
      parked   <= (next_state == S_PARK);
      gap_pda  <= (state == S_MRS_CMD) ? pda_on : gap_pda;
      xmp_done <= (state == S_PARK) ? 1'b0 :
                  (state == S_WAKE_DES && seq_t.done) ? 1'b1 : xmp_done;
      dll_ok   <= (state == S_PARK || state == S_WAKE_CK) ? 1'b0 :
                  dll_t.done ? 1'b1 : dll_ok;
      if (mrs_lands && m_sel == MR_PDA) begin
        pda_on <= m_addr[PDA_BIT];
      end
      if (mrs_lands && m_sel == MR_VREF) begin
        vref_set <= 1'b1;
      end
    end
  end

  // sticky errors; a new error wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ref <= 1'b0;
      err_res <= 1'b0;
    end else begin
      err_ref <= (mrs_bad && !vref_bad) || exit_bad || park_bad
                 || (err_ref && !(st_clr && pwdata[ST_ERR_REF]));
      err_res <= (go_mrs && vref_bad)
                 || (err_res && !(st_clr && pwdata[ST_ERR_RES]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !mapped;
      prdata  <= rd_mux;
    end
  end

  sequence s_mrs_out;
    !cs_n && cmd == CMD_MRS;
  endsequence
  sequence s_quiet4;
    (cs_n)[*4];
  endsequence

  chk_cs_at_cke: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cke) |-> !cs_n)
    else $error("cs_n not low at cke rise");
  chk_clock_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cke) |-> ck_en && $past(ck_en, 4))
    else $error("clock not running before cke rise");
  chk_nop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cke) |-> (!cs_n && cmd == CMD_NOP)[*2] ##[1:40] cs_n)
    else $error("nop hold or des phase wrong");
  chk_exit_first: assert property (@(posedge pclk) disable iff (!presetn)
    s_mrs_out |-> xmp_done)
    else $error("mrs issued inside exit interval");
  chk_dq_steady: assert property (@(posedge pclk) disable iff (!presetn)
    dq0_oe && $past(dq0_oe) |-> $stable(dq0_out))
    else $error("dq0 changed within burst");
  chk_wl_before: assert property (@(posedge pclk) disable iff (!presetn)
    (s_mrs_out and (mr_sel == MR_PDA && mr_addr[PDA_BIT])) |-> wl_done)
    else $error("per-device mode before leveling");
  chk_only_mrs: assert property (@(posedge pclk) disable iff (!presetn)
    pda_on && !cs_n |-> cmd == CMD_MRS)
    else $error("non-mrs command in per-device mode");
  chk_mrs_space: assert property (@(posedge pclk) disable iff (!presetn)
    (s_mrs_out and pda_on) |=> s_quiet4)
    else $error("mrs spacing too short");
  chk_pda_exit_low: assert property (@(posedge pclk) disable iff (!presetn)
    dq0_oe && mr_sel == MR_PDA && !mr_addr[PDA_BIT] |-> !dq0_out)
    else $error("per-device exit with dq0 high");
  chk_odt_pda: assert property (@(posedge pclk) disable iff (!presetn)
    odt |-> gap_pda && dq0_oe)
    else $error("odt driven outside per-device burst");
  chk_vref_code: assert property (@(posedge pclk) disable iff (!presetn)
    go_mrs && vref_bad |=> state == S_IDLE ##1 err_res)
    else $error("reserved vref code not refused");
endmodule

// file: bench/dpc_dram_model.sv
// behavioural dram: power-save exit, per-device mrs and vref register
`timescale 1ns/10ps
module dpc_dram_model
  import dpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ck_en,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic [1:0]  cmd,
  input  wire logic [2:0]  mr_sel,
  input  wire logic [13:0] mr_addr,
  input  wire logic        dq0,
  input  wire logic        dq0_oe,
  input  wire logic        dqs,
  input  wire logic        dqs_oe,
  input  wire logic        odt,
  input  wire logic [5:0]  lat,
  output logic             parked,
  output logic      [13:0] mr3,
  output logic      [13:0] mr6,
  output logic             vref_ok,
  output logic             odt_seen,
  output logic      [7:0]  viol
);
  // no parity input: address parity does not exist here
  logic [15:0] since_cke, since_mrs, ck_on;
  logic [7:0]  viol_c;
  logic [7:0]  viol_x = 8'h0;
  logic        park_q = 1'b0;
  logic        pend, cap;
  logic [2:0]  beat, p_sel;
  logic [13:0] p_addr;
  wire         pda     = mr3[PDA_BIT];
  wire         sel_cmd = ck_en && !cs_n;
  assign parked = park_q;
  assign viol   = viol_c + viol_x;

  task automatic exec(input logic [2:0] s, input logic [13:0] a);
    if (s == MR_PDA) mr3 <= a;
    if (s == MR_VREF && a[5:0] <= VREF_MAX) begin
      mr6 <= a;
      vref_ok <= 1'b1;
    end
  endtask

  // clock receivers are off while parked, so cs_n is caught on cke
  always @(posedge cke or negedge cke or negedge presetn) begin
    if (!presetn) begin
      park_q <= 1'b0;
    end else if (!cke) begin
      park_q <= 1'b1;
    end else if (park_q && !cs_n) begin
      park_q <= 1'b0;
      if (!ck_en || ck_on < CKMPX_CYC) viol_x <= viol_x + 8'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_cke <= 16'hffff;
      since_mrs <= 16'hffff;
      ck_on <= 16'h0;
      viol_c <= 8'h0;
      pend <= 1'b0;
      cap <= 1'b0;
      beat <= 3'h0;
      p_sel <= 3'h0;
      p_addr <= 14'h0;
      mr3 <= 14'h0;
      mr6 <= 14'h0;
      vref_ok <= 1'b0;
      odt_seen <= 1'b0;
    end else begin
      ck_on <= !ck_en ? 16'h0 : ck_on + {15'h0, !cke};
      since_cke <= !cke ? 16'h0 : since_cke + {15'h0, since_cke != 16'hffff};
      since_mrs <= since_mrs + {15'h0, since_mrs != 16'hffff};
      if (cke && since_cke < XMP_CYC) begin
        if (since_cke < XMPLH_CYC ? (cs_n || cmd != CMD_NOP)
                                  : (sel_cmd && cmd != CMD_NOP))
          viol_c <= viol_c + 8'h1;
      end else if (!park_q && sel_cmd && cmd == CMD_MRS) begin
        since_mrs <= 16'h0;
        if (pda && since_mrs < lat + SPACE_EXTRA_CK + MRD_PDA_CYC)
          viol_c <= viol_c + 8'h1;
        if (pda) begin
          pend <= 1'b1;
          p_sel <= mr_sel;
          p_addr <= mr_addr;
        end else begin
          exec(mr_sel, mr_addr);
        end
      end else if (pda && sel_cmd) begin
        viol_c <= viol_c + 8'h1;
      end
      if (pend && dq0_oe) begin
        beat <= beat + 3'h1;
        odt_seen <= odt_seen | odt;
        if (dqs_oe !== 1'b1 || dqs !== !beat[0])
          viol_c <= viol_c + 8'h1;
        if (beat == 3'h0) cap <= dq0;
        else if (dq0 !== cap) viol_c <= viol_c + 8'h1;
      end else if (pend && beat != 3'h0) begin
        pend <= 1'b0;
        beat <= 3'h0;
        if (!cap) exec(p_sel, p_addr);
      end
    end
  end
endmodule

// file: bench/tb_dram_mode_exit_pda_vref_control.sv
// self-checking bench for the power-save exit and mrs controller
`timescale 1ns/10ps
module tb_dram_mode_exit_pda_vref_control
  import dpc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, slv;
  logic [7:0]  paddr, viol;
  logic [31:0] pwdata, prdata, rdat, st;
  logic        pready, pslverr, ck_en, cke, cs_n, dq0_out, dq0_oe;
  logic        dqs_out, dqs_oe, odt, parked, vref_ok, odt_seen;
  logic [1:0]  cmd;
  logic [2:0]  mr_sel;
  logic [13:0] mr_addr, mr3, mr6, a, prev;
  logic [5:0]  lat, code;
  integer      num_errors, comparisons, seed, i;
  integer      cyc = 0;

  dpc_ctrl #(.DLL_CYC(60)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ck_en, .cke, .cs_n, .cmd,
    .mr_sel, .mr_addr, .dq0_out, .dq0_oe, .dqs_out, .dqs_oe, .odt);
  dpc_dram_model dram (.pclk, .presetn, .ck_en, .cke, .cs_n, .cmd, .mr_sel,
    .mr_addr, .dq0(dq0_out), .dq0_oe, .dqs(dqs_out), .dqs_oe, .odt, .lat,
    .parked, .mr3, .mr6, .vref_ok, .odt_seen, .viol);

  task stop_test;
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_st;
    apb(1'b0, REG_STATUS, 32'h0);
    st = rdat;
  endtask

  task wait_bit(input int b);
    rd_st;
    while (st[b] !== 1'b1) rd_st;
  endtask

  // the model applies a per-device mrs only after its burst ends
  task mrs(input logic [2:0] s, input logic [13:0] ad, input logic skip);
    apb(1'b1, REG_MRS, {14'h0, skip, s, ad});
    apb(1'b1, REG_CTRL, 32'h4);
    wait_bit(ST_IDLE);
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    seed = 37172;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 6'h1 + 6'($unsigned($random(seed)) % 4);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_st;
    chk(st, 32'h0d);
    chk({17'h0, vref_ok, mr3}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rdat[30:0], slv}, 32'h1);
    // park, then a command that the parked device must not see
    apb(1'b1, REG_CTRL, 32'h1);
    wait_bit(ST_PARKED);
    apb(1'b1, REG_MRS, 32'h18000);
    apb(1'b1, REG_CTRL, 32'h4);
    rd_st;
    chk({29'h0, parked, st[6], st[1]}, 32'h7);
    apb(1'b1, REG_STATUS, 32'hc0);
    // commands refused in the exit interval, dll ones until lock
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b1, REG_MRS, 32'h58000);
    apb(1'b1, REG_CTRL, 32'h4);
    wait_bit(ST_XMP_DONE);
    chk({30'h0, parked, st[6]}, 32'h1);
    apb(1'b1, REG_STATUS, 32'hc0);
    apb(1'b1, REG_MRS, 32'h58000);
    apb(1'b1, REG_CTRL, 32'h4);
    rd_st;
    chk({30'h0, st[ST_DLL_OK], st[6]}, 32'h1);
    apb(1'b1, REG_STATUS, 32'hc0);
    wait_bit(ST_DLL_OK);
    // level sweep with both range settings, boundary codes first
    for (i = 0; i < 8; i++) begin
      code = (i == 0) ? 6'h32 : (i == 1) ? 6'h33 : 6'($random(seed));
      a = {7'h0, 1'($random(seed)), code};
      prev = mr6;
      mrs(MR_VREF, a, 1'b0);
      rd_st;
      chk({18'h0, mr6}, {18'h0, code <= VREF_MAX ? a : prev});
      chk({31'h0, st[ST_ERR_RES]}, {31'h0, code > VREF_MAX});
      apb(1'b1, REG_STATUS, 32'hc0);
    end
    chk({30'h0, vref_ok, st[ST_VREF_SET]}, 32'h3);
    apb(1'b1, REG_CFG, {26'h0, lat});
    mrs(MR_PDA, 14'h10, 1'b0);
    rd_st;
    chk({30'h0, mr3[PDA_BIT], st[6]}, 32'h1);
    apb(1'b1, REG_STATUS, 32'hc0);
    apb(1'b1, REG_CFG, {24'h0, 2'b11, lat});
    a = 14'($random(seed)) | 14'h10;
    mrs(MR_PDA, a, 1'b0);
    rd_st;
    chk({17'h0, st[ST_PDA], mr3}, {17'h1, a});
    for (i = 0; i < 4; i++) begin
      a = {8'h0, 6'($unsigned($random(seed)) % 51)};
      prev = mr6;
      mrs(MR_VREF, a, i[0]);
      chk({18'h0, mr6}, {18'h0, i[0] ? prev : a});
    end
    chk({31'h0, odt_seen}, 32'h1);
    a = 14'($random(seed)) & 14'h3fef;
    mrs(MR_PDA, a, 1'b1);
    rd_st;
    chk({17'h0, st[ST_PDA], mr3}, {18'h0, a});
    chk({24'h0, viol}, 32'h0);
    stop_test;
  end
endmodule
